// [rtl/smbw_pkg.sv]
package smbw_pkg;

  // -------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_SCL_QUARTER_NS = 1250;
  localparam int QTR_CYC = (T_SCL_QUARTER_NS * 1000) / CLK_PERIOD_PS;
  localparam int QCNT_W = 10;
  localparam logic [QCNT_W-1:0] QTR_LAST = QCNT_W'(QTR_CYC - 1);

  // -------------------------------------------------------------
  // Framing
  // -------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;
  localparam int STRAP_W = 2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic RW_WRITE = 1'b0;
  // Base target address, arbitrary value
  localparam logic [ADDR_W-1:0] DEV_ADDR_BASE = 7'h50;

  // -------------------------------------------------------------
  // Types
  // -------------------------------------------------------------
  typedef enum logic [3:0] {
    DS_IDLE = 4'b0001,
    DS_RECV = 4'b0010,
    DS_ACK = 4'b0100,
    DS_SKIP = 4'b1000
  } smbw_dstate_t;

  typedef enum logic [3:0] {
    PH_ADDR = 4'b0001,
    PH_INDEX = 4'b0010,
    PH_COUNT = 4'b0100,
    PH_DATA = 4'b1000
  } smbw_phase_t;

  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001,
    HS_START = 5'b00010,
    HS_BIT = 5'b00100,
    HS_ACK = 5'b01000,
    HS_STOP = 5'b10000
  } smbw_hstate_t;

endpackage

// [rtl/smbw_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface smbw_if;
  logic scl_h_o;
  logic scl_h_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;

  // -------------------------------------------------------------
  // Wired-AND with pull-up
  // -------------------------------------------------------------
  assign scl = scl_h_oe ? scl_h_o : 1'b1;
  assign sda = (sda_h_oe ? sda_h_o : 1'b1) & (sda_d_oe ? sda_d_o : 1'b1);

  modport dev (input scl, input sda, output sda_d_o, output sda_d_oe);
  modport host (input scl, input sda, output scl_h_o, output scl_h_oe,
                output sda_h_o, output sda_h_oe);
endinterface
`default_nettype wire

// [rtl/smbw_target.sv]
// Functional notes
// [RQ1] Host opens every write with start
// [RQ2] Write address sent; matching device acknowledges
// [RQ3] Index byte N sent and acknowledged
// [RQ4] Count byte X sent and acknowledged
// [RQ5] Host sends exactly X data bytes
// [RQ6] Device acknowledges every data byte
// [RQ7] Host ends with stop after last ack
// [RQ8] Address taken from latched strap level
// [RQ9] Byte k stored at index N plus k
`timescale 1ns/10ps
`default_nettype none
module smbw_target
  import smbw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [STRAP_W-1:0] address_select_strap,
  smbw_if.dev bus,
  output logic [ADDR_W-1:0] own_addr,
  output logic wr_valid,
  output logic [BYTE_W-1:0] wr_index,
  output logic [BYTE_W-1:0] wr_data,
  output logic busy
);

  // -------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------
  logic scl_s1_reg;
  logic scl_s2_reg;
  logic scl_s3_reg;
  logic sda_s1_reg;
  logic sda_s2_reg;
  logic sda_s3_reg;
  logic [STRAP_W-1:0] strap_s1_reg;
  logic [STRAP_W-1:0] strap_s2_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
      strap_s1_reg <= '0;
      strap_s2_reg <= '0;
    end else begin
      scl_s1_reg <= bus.scl;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= bus.sda;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
      strap_s1_reg <= address_select_strap;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise = scl_s2_reg & ~scl_s3_reg;
  assign scl_fall = ~scl_s2_reg & scl_s3_reg;
  assign start_det = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
  assign stop_det = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;

  // -------------------------------------------------------------
  // Strap latch
  // -------------------------------------------------------------
  logic [1:0] strap_cnt_reg;
  logic [1:0] strap_cnt_next;
  logic addr_ok_reg;
  logic addr_ok_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;

  always_comb begin
    strap_cnt_next = strap_cnt_reg;
    addr_ok_next = addr_ok_reg;
    addr_next = addr_reg;
    if (!addr_ok_reg) begin
      if (strap_cnt_reg == STRAP_SETTLE) begin
        addr_next = DEV_ADDR_BASE + ADDR_W'(strap_s2_reg); // RQ8
        addr_ok_next = 1'b1; // RQ8
      end else begin
        strap_cnt_next = strap_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_cnt_reg <= '0;
      addr_ok_reg <= 1'b0;
      addr_reg <= DEV_ADDR_BASE;
    end else begin
      strap_cnt_reg <= strap_cnt_next;
      addr_ok_reg <= addr_ok_next;
      addr_reg <= addr_next;
    end
  end

  // -------------------------------------------------------------
  // Transaction engine
  // -------------------------------------------------------------
  smbw_dstate_t state_reg;
  smbw_dstate_t state_next;
  smbw_phase_t phase_reg;
  smbw_phase_t phase_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [BYTE_W-1:0] shift_reg;
  logic [BYTE_W-1:0] shift_next;
  logic [BYTE_W-1:0] ptr_reg;
  logic [BYTE_W-1:0] ptr_next;
  logic [BYTE_W-1:0] remain_reg;
  logic [BYTE_W-1:0] remain_next;
  logic sda_oe_reg;
  logic sda_oe_next;
  logic wr_valid_reg;
  logic wr_valid_next;
  logic [BYTE_W-1:0] wr_index_reg;
  logic [BYTE_W-1:0] wr_index_next;
  logic [BYTE_W-1:0] wr_data_reg;
  logic [BYTE_W-1:0] wr_data_next;

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    remain_next = remain_reg;
    sda_oe_next = sda_oe_reg;
    wr_valid_next = 1'b0;
    wr_index_next = wr_index_reg;
    wr_data_next = wr_data_reg;
    if (stop_det) begin
      state_next = DS_IDLE;
      sda_oe_next = 1'b0;
    end else if (start_det) begin
      // Start or repeated start restarts framing
      state_next = DS_RECV;
      phase_next = PH_ADDR;
      bit_cnt_next = '0;
      sda_oe_next = 1'b0;
    end else begin
      case (state_reg)
        DS_RECV: begin
          if (scl_rise && bit_cnt_reg != BITS_PER_BYTE) begin
            shift_next = {shift_reg[BYTE_W-2:0], sda_s2_reg};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
            state_next = DS_ACK;
            sda_oe_next = 1'b1;
            case (phase_reg)
              PH_ADDR: begin
                if (shift_reg[BYTE_W-1:1] == addr_reg && shift_reg[0] == RW_WRITE
                    && addr_ok_reg) begin
                  phase_next = PH_INDEX; // RQ2
                end else begin
                  state_next = DS_SKIP;
                  sda_oe_next = 1'b0;
                end
              end
              PH_INDEX: begin
                ptr_next = shift_reg; // RQ3
                phase_next = PH_COUNT; // RQ3
              end
              PH_COUNT: begin
                remain_next = shift_reg; // RQ4
                phase_next = PH_DATA; // RQ4
              end
              PH_DATA: begin
                if (remain_reg != '0) begin
                  wr_valid_next = 1'b1; // RQ6
                  wr_index_next = ptr_reg; // RQ9
                  wr_data_next = shift_reg;
                  ptr_next = ptr_reg + 8'h01; // RQ9
                  remain_next = remain_reg - 8'h01;
                end else begin
                  // Bytes beyond the count are refused
                  state_next = DS_SKIP;
                  sda_oe_next = 1'b0;
                end
              end
              default: begin
                state_next = DS_SKIP;
                sda_oe_next = 1'b0;
              end
            endcase
          end
        end
        DS_ACK: begin
          if (scl_fall) begin
            // Release after the acknowledge clock
            sda_oe_next = 1'b0;
            bit_cnt_next = '0;
            state_next = DS_RECV;
          end
        end
        DS_SKIP: begin
          sda_oe_next = 1'b0;
        end
        default: begin
          sda_oe_next = 1'b0;
          state_next = DS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= DS_IDLE;
      phase_reg <= PH_ADDR;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      ptr_reg <= '0;
      remain_reg <= '0;
      sda_oe_reg <= 1'b0;
      wr_valid_reg <= 1'b0;
      wr_index_reg <= '0;
      wr_data_reg <= '0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      remain_reg <= remain_next;
      sda_oe_reg <= sda_oe_next;
      wr_valid_reg <= wr_valid_next;
      wr_index_reg <= wr_index_next;
      wr_data_reg <= wr_data_next;
    end
  end

  // -------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------
  logic sda_o_reg;
  logic busy_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_o_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      sda_o_reg <= 1'b0;
      busy_reg <= (state_next != DS_IDLE);
    end
  end

  assign bus.sda_d_o = sda_o_reg;
  assign bus.sda_d_oe = sda_oe_reg;
  assign own_addr = addr_reg;
  assign wr_valid = wr_valid_reg;
  assign wr_index = wr_index_reg;
  assign wr_data = wr_data_reg;
  assign busy = busy_reg;

endmodule
`default_nettype wire

// [rtl/smbw_host.sv]
`timescale 1ns/10ps
`default_nettype none
module smbw_host
  import smbw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  smbw_if.host bus,
  input wire logic go,
  input wire logic [ADDR_W-1:0] target_addr,
  input wire logic [BYTE_W-1:0] start_index,
  input wire logic [BYTE_W-1:0] byte_count,
  input wire logic [BYTE_W-1:0] data_byte,
  output logic data_next,
  output logic busy,
  output logic done,
  output logic nacked
);

  // -------------------------------------------------------------
  // Pin synchroniser
  // -------------------------------------------------------------
  logic sda_s1_reg;
  logic sda_s2_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end else begin
      sda_s1_reg <= bus.sda;
      sda_s2_reg <= sda_s1_reg;
    end
  end

  // -------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------
  smbw_hstate_t state_reg;
  smbw_hstate_t state_next;
  smbw_phase_t phase_reg;
  smbw_phase_t phase_next;
  logic [QCNT_W-1:0] qcnt_reg;
  logic [QCNT_W-1:0] qcnt_next;
  logic [1:0] q_reg;
  logic [1:0] q_next;
  logic [2:0] bit_reg;
  logic [2:0] bit_next;
  logic [BYTE_W-1:0] tx_reg;
  logic [BYTE_W-1:0] tx_next;
  logic [BYTE_W-1:0] idx_reg;
  logic [BYTE_W-1:0] idx_next;
  logic [BYTE_W-1:0] rem_reg;
  logic [BYTE_W-1:0] rem_next;
  logic scl_oe_reg;
  logic scl_oe_next;
  logic sda_oe_reg;
  logic sda_oe_next;
  logic nack_reg;
  logic nack_next;
  logic done_reg;
  logic done_next;
  logic dnext_reg;
  logic dnext_next;
  logic tick;

  assign tick = (qcnt_reg == QTR_LAST);

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    qcnt_next = tick ? '0 : qcnt_reg + QCNT_W'(1);
    q_next = q_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    idx_next = idx_reg;
    rem_next = rem_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    nack_next = nack_reg;
    done_next = 1'b0;
    dnext_next = 1'b0;
    if (tick && state_reg != HS_IDLE) begin
      q_next = q_reg + 2'h1;
    end
    case (state_reg)
      HS_IDLE: begin
        qcnt_next = '0;
        q_next = '0;
        scl_oe_next = 1'b0;
        sda_oe_next = 1'b0;
        if (go) begin
          state_next = HS_START;
          tx_next = {target_addr, RW_WRITE}; // RQ2
          idx_next = start_index;
          rem_next = byte_count;
          nack_next = 1'b0;
        end
      end
      HS_START: begin
        if (tick) begin
          case (q_reg)
            2'h0: sda_oe_next = 1'b1; // RQ1
            2'h1: scl_oe_next = 1'b1;
            default: begin
              state_next = HS_BIT;
              phase_next = PH_ADDR;
              q_next = '0;
              bit_next = '0;
              sda_oe_next = ~tx_reg[BYTE_W-1];
            end
          endcase
        end
      end
      HS_BIT: begin
        if (tick) begin
          case (q_reg)
            2'h0: scl_oe_next = 1'b0;
            2'h2: scl_oe_next = 1'b1;
            2'h3: begin
              if (bit_reg == LAST_BIT) begin
                state_next = HS_ACK;
                sda_oe_next = 1'b0;
              end else begin
                bit_next = bit_reg + 3'h1;
                tx_next = {tx_reg[BYTE_W-2:0], 1'b0};
                sda_oe_next = ~tx_reg[BYTE_W-2];
              end
            end
            default: scl_oe_next = 1'b0;
          endcase
        end
      end
      HS_ACK: begin
        if (tick) begin
          case (q_reg)
            2'h0: scl_oe_next = 1'b0;
            2'h1: nack_next = sda_s2_reg;
            2'h2: scl_oe_next = 1'b1;
            default: begin
              bit_next = '0;
              if (nack_reg) begin
                state_next = HS_STOP;
                sda_oe_next = 1'b1;
              end else begin
                state_next = HS_BIT;
                case (phase_reg)
                  PH_ADDR: begin
                    phase_next = PH_INDEX;
                    tx_next = idx_reg; // RQ3
                    sda_oe_next = ~idx_reg[BYTE_W-1];
                  end
                  PH_INDEX: begin
                    phase_next = PH_COUNT;
                    tx_next = rem_reg; // RQ4
                    sda_oe_next = ~rem_reg[BYTE_W-1];
                  end
                  default: begin
                    phase_next = PH_DATA;
                    if (rem_reg == '0) begin
                      state_next = HS_STOP; // RQ7
                      sda_oe_next = 1'b1;
                    end else begin
                      tx_next = data_byte; // RQ5
                      sda_oe_next = ~data_byte[BYTE_W-1];
                      rem_next = rem_reg - 8'h01; // RQ5
                      dnext_next = 1'b1;
                    end
                  end
                endcase
              end
            end
          endcase
        end
      end
      HS_STOP: begin
        if (tick) begin
          case (q_reg)
            2'h0: scl_oe_next = 1'b0;
            2'h1: sda_oe_next = 1'b0; // RQ7
            default: begin
              state_next = HS_IDLE;
              done_next = 1'b1;
            end
          endcase
        end
      end
      default: state_next = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= HS_IDLE;
      phase_reg <= PH_ADDR;
      qcnt_reg <= '0;
      q_reg <= '0;
      bit_reg <= '0;
      tx_reg <= '0;
      idx_reg <= '0;
      rem_reg <= '0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      nack_reg <= 1'b0;
      done_reg <= 1'b0;
      dnext_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      qcnt_reg <= qcnt_next;
      q_reg <= q_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      idx_reg <= idx_next;
      rem_reg <= rem_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      nack_reg <= nack_next;
      done_reg <= done_next;
      dnext_reg <= dnext_next;
    end
  end

  // -------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------
  logic zero_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      zero_reg <= 1'b0;
    end else begin
      zero_reg <= 1'b0;
    end
  end

  assign bus.scl_h_o = zero_reg;
  assign bus.sda_h_o = zero_reg;
  assign bus.scl_h_oe = scl_oe_reg;
  assign bus.sda_h_oe = sda_oe_reg;
  assign data_next = dnext_reg;
  assign busy = (state_reg != HS_IDLE);
  assign done = done_reg;
  assign nacked = nack_reg;

endmodule
`default_nettype wire

// [verification/smbw_checker_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module smbw_checker
  import smbw_pkg::*;
#(
  parameter logic [ADDR_W-1:0] EXP_ADDR = DEV_ADDR_BASE
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_h_o,
  input wire logic scl_h_oe,
  input wire logic sda_h_o,
  input wire logic sda_h_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  // -------------------------------------------------------------
  // Frame tracking
  // -------------------------------------------------------------
  logic scl_reg, sda_reg, framed_reg, addr_ok_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg, byte_reg, cnt_reg, data_reg;
  wire logic rise = scl && !scl_reg;
  wire logic start_ev = scl && scl_reg && sda_reg && !sda;
  wire logic stop_ev = scl && scl_reg && !sda_reg && sda;
  wire logic ack_slot = rise && framed_reg && bit_reg == 4'h8;

  always_ff @(posedge clk) begin
    scl_reg <= scl;
    sda_reg <= sda;
    if (!rst_n) begin
      framed_reg <= 1'b0;
      addr_ok_reg <= 1'b0;
      bit_reg <= 4'h0;
      byte_reg <= 8'h00;
      data_reg <= 8'h00;
      cnt_reg <= 8'h00;
      sh_reg <= 8'h00;
    end else if (start_ev) begin
      framed_reg <= 1'b1;
      addr_ok_reg <= 1'b0;
      bit_reg <= 4'h0;
      byte_reg <= 8'h00;
      data_reg <= 8'h00;
    end else if (stop_ev) begin
      framed_reg <= 1'b0;
    end else if (ack_slot) begin
      bit_reg <= 4'h0;
      if (byte_reg == 8'h00) addr_ok_reg <= !sda;
      if (byte_reg == 8'h02) cnt_reg <= sh_reg;
      if (byte_reg >= 8'h03) data_reg <= data_reg + 8'h01;
      if (byte_reg != 8'hff) byte_reg <= byte_reg + 8'h01;
    end else if (rise && framed_reg) begin
      sh_reg <= {sh_reg[6:0], sda};
      bit_reg <= bit_reg + 4'h1;
    end
  end

  // -------------------------------------------------------------
  // Acknowledge window
  // -------------------------------------------------------------
  localparam int ACK_HIGH_MAX = 2 * QTR_CYC + 100;
  logic ack_win_reg;
  logic [10:0] ack_cnt_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_win_reg <= 1'b0;
      ack_cnt_reg <= 11'h000;
    end else if (ack_slot && sda_d_oe) begin
      ack_win_reg <= 1'b1;
      ack_cnt_reg <= 11'h000;
    end else if (!scl) begin
      ack_win_reg <= 1'b0;
    end else if (ack_win_reg) begin
      ack_cnt_reg <= ack_cnt_reg + 11'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  property p_scl_framed;
    $fell(scl) |-> framed_reg;
  endproperty
  a_scl_framed: assert property (p_scl_framed) else $error("scl clocked outside frame");
  property p_addr_ack;
    ack_slot && byte_reg == 8'h00 && !sda |-> sh_reg == {EXP_ADDR, RW_WRITE};
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("foreign address acked");
  property p_addr_match;
    ack_slot && byte_reg == 8'h00 && sh_reg == {EXP_ADDR, RW_WRITE} |-> sda_d_oe && !sda;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("own address not acked");
  property p_index_ack;
    ack_slot && byte_reg == 8'h01 && addr_ok_reg |-> sda_d_oe;
  endproperty
  a_index_ack: assert property (p_index_ack) else $error("index byte not acked");
  property p_count_ack;
    ack_slot && byte_reg == 8'h02 && addr_ok_reg |-> sda_d_oe;
  endproperty
  a_count_ack: assert property (p_count_ack) else $error("count byte not acked");
  property p_data_ack;
    ack_slot && byte_reg >= 8'h03 && addr_ok_reg && (byte_reg - 8'h03) < cnt_reg |-> sda_d_oe;
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("data byte not acked");
  property p_ack_holds;
    ack_win_reg |-> sda_d_oe && ack_cnt_reg < 11'(ACK_HIGH_MAX);
  endproperty
  a_ack_holds: assert property (p_ack_holds) else $error("ack dropped while scl high");
  property p_stop_count;
    stop_ev && addr_ok_reg && byte_reg >= 8'h03 |-> data_reg == cnt_reg;
  endproperty
  a_stop_count: assert property (p_stop_count) else $error("data bytes differ from count");
  property p_stop_edge;
    stop_ev |-> bit_reg == 4'h1 && !sda_d_oe;
  endproperty
  a_stop_edge: assert property (p_stop_edge) else $error("stop not on byte boundary");

  c_good_frame: cover property (stop_ev && addr_ok_reg && byte_reg >= 8'h04);
  c_addr_nack: cover property (ack_slot && byte_reg == 8'h00 && sda);
  c_data_ack: cover property (ack_slot && byte_reg >= 8'h03 && sda_d_oe);
endmodule
`default_nettype wire

// [verification/smbus_block_write_target_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module smbus_block_write_target_bench;
  import smbw_pkg::*;
  `define CHK(a, b) begin total_checks++; if ((a) !== (b)) report_err(); end

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [STRAP_W-1:0] strap = 2'h2;
  logic go = 1'b0;
  logic [ADDR_W-1:0] t_addr = 7'h00;
  logic [BYTE_W-1:0] n_idx = 8'h00;
  logic [BYTE_W-1:0] x_cnt = 8'h00;
  logic [BYTE_W-1:0] data_byte = 8'h00;
  logic [ADDR_W-1:0] own_addr;
  logic [BYTE_W-1:0] wr_index, wr_data;
  logic wr_valid, t_busy, data_next, h_busy, done, nacked;
  int failures = 0;
  int total_checks = 0;
  int k_tx = 0;
  int k_rx = 0;
  int nbit = 0;
  logic [BYTE_W-1:0] data_q[$];
  logic [BYTE_W-1:0] frame_q[$];
  logic ack_q[$];
  logic [8:0] sh = 9'h000;

  always #2.5 clk = ~clk;

  smbw_if bus_if();
  smbw_target i_smbw_target (.clk(clk), .rst_n(rst_n), .address_select_strap(strap),
    .bus(bus_if), .own_addr(own_addr), .wr_valid(wr_valid), .wr_index(wr_index),
    .wr_data(wr_data), .busy(t_busy));
  smbw_host i_smbw_host (.clk(clk), .rst_n(rst_n), .bus(bus_if), .go(go),
    .target_addr(t_addr), .start_index(n_idx), .byte_count(x_cnt), .data_byte(data_byte),
    .data_next(data_next), .busy(h_busy), .done(done), .nacked(nacked));
  smbw_checker #(.EXP_ADDR(DEV_ADDR_BASE + 7'h2)) i_smbw_checker (.clk(clk), .rst_n(rst_n),
    .scl_h_o(bus_if.scl_h_o), .scl_h_oe(bus_if.scl_h_oe), .sda_h_o(bus_if.sda_h_o),
    .sda_h_oe(bus_if.sda_h_oe), .sda_d_o(bus_if.sda_d_o), .sda_d_oe(bus_if.sda_d_oe),
    .scl(bus_if.scl), .sda(bus_if.sda));

  task report_err;
    begin
      failures++;
      $display("[ERR] %0t value mismatch", $time);
    end
  endtask

  task close_out;
    begin
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // -------------------------------------------------------------
  // Host data feed and target write monitor
  // -------------------------------------------------------------
  always @(negedge clk) begin
    if (data_next === 1'b1) begin
      k_tx = k_tx + 1;
      data_byte = (k_tx < data_q.size()) ? data_q[k_tx] : 8'h00;
    end
    if (rst_n && wr_valid === 1'b1) begin
      `CHK(wr_index, n_idx + 8'(k_rx))
      `CHK(wr_data, data_q[k_rx])
      `CHK(t_busy, 1'b1)
      k_rx++;
    end
  end

  // -------------------------------------------------------------
  // Wire sniffer
  // -------------------------------------------------------------
  always @(negedge bus_if.sda) if (bus_if.scl === 1'b1) nbit = 0;
  always @(posedge bus_if.scl) begin
    sh = {sh[7:0], bus_if.sda};
    nbit++;
    if (nbit == 9) begin
      frame_q.push_back(sh[8:1]);
      ack_q.push_back(sh[0]);
      nbit = 0;
    end
  end

  task run_write(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] n,
                 input logic [BYTE_W-1:0] x, input logic exp_nack);
    int i;
    begin
      k_tx = 0;
      k_rx = 0;
      frame_q.delete();
      ack_q.delete();
      @(negedge clk);
      t_addr = a;
      n_idx = n;
      x_cnt = x;
      data_byte = data_q[0];
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      `CHK(h_busy, 1'b1)
      i = 0;
      while (done !== 1'b1 && i < 100000) begin
        @(negedge clk);
        i++;
      end
      `CHK(done, 1'b1)
      `CHK(h_busy, 1'b0)
      `CHK(t_busy, 1'b0)
      `CHK(nacked, exp_nack)
      `CHK(frame_q[0], {a, RW_WRITE})
      if (exp_nack) begin
        `CHK(ack_q[0], 1'b1)
        `CHK(k_rx, 0)
      end else begin
        `CHK(frame_q.size(), 3 + int'(x))
        `CHK(frame_q[1], n)
        `CHK(frame_q[2], x)
        `CHK(k_rx, int'(x))
        foreach (ack_q[j]) `CHK(ack_q[j], 1'b0)
      end
    end
  endtask

  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (12) @(negedge clk);
    `CHK(own_addr, DEV_ADDR_BASE + 7'h2)
    strap = 2'h0;
    data_q = '{8'ha5};
    run_write(DEV_ADDR_BASE + 7'h1, 8'h10, 8'h01, 1'b1);
    `CHK(own_addr, DEV_ADDR_BASE + 7'h2)
    data_q = '{8'h3c, 8'hc3};
    run_write(DEV_ADDR_BASE + 7'h2, 8'hff, 8'h02, 1'b0);
    close_out();
  end

  initial begin
    #400000;
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
